// File: core/adc_scan_control.sv
// apb register block, scan result fifo and start control of the converter
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_map.svh"
module adc_scan_control
   import adc_scan_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timerTrigger,
   input  wire logic        resultValid,
   input  wire logic [11:0] resultValue,
   input  wire logic [4:0]  resultChannel,
   input  wire logic        passDone,
   input  wire logic        priorityIrqEvent,
   input  wire logic        compareMatchEvent,
   input  wire logic        priorityOverrunFlag,
   input  wire logic        level1Start,
   input  wire logic        level2Start,
   input  wire logic        priorityDone,
   output logic             irqScan,
   output logic             irqPriority,
   output logic             irqCompare,
   output logic             irqOverrun,
   output logic             scanStartPulse,
   output logic             convHalt,
   output logic             placementSelect
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic       seqIrqFlag, priorityIrqFlag, compareMatchFlag;
   logic       seqIrqEnable, priorityIrqEnable;
   logic       compareIrqEnable, overrunIrqEnable;
   logic       seqOverrunFlag, repeatMode, seqTimerStartEnable;
   logic [3:0] seqFifoThreshold;
   logic       sequenceBusyFlag, level1Active, level2Active;
   logic       level2PendingFlag, timerPrev;
   origin_t    runOrigin;
   entry_t     mem [DEPTH];
   logic [3:0] writePtr, readPtr;
   logic [4:0] count;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire access   = psel & penable;
   wire wr       = access & pwrite;
   wire rd       = access & ~pwrite;
   wire selIc    = paddr == `OFF_IRQ_CTRL;
   wire selSt    = paddr == `OFF_STATUS;
   wire selSc    = paddr == `OFF_SEQ_CTRL;
   wire selTh    = paddr == `OFF_SEQ_THR;
   wire selFd    = paddr == `OFF_SEQ_DATA;
   wire mapped   = selIc | selSt | selSc | selTh | selFd;
   // reserved bits never reach a flop
   wire wrIcHi   = wr & selIc & pstrb[1];
   wire wrStLo   = wr & selSt & pstrb[0];
   wire wrScHi   = wr & selSc & pstrb[1];
   wire wrThLo   = wr & selTh & pstrb[0];

   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // ----------------------------------------
   // start, halt and fifo events
   // ----------------------------------------
   wire forcedHalt = wrStLo & pwdata[`B_HALT];
   wire softStart  = wrScHi & pwdata[`B_SOFT_START];
   wire fifoClear  = wrScHi & pwdata[`B_CLEAR];
   // soft start masks a timer edge in the same cycle
   wire timerStart = seqTimerStartEnable & timerTrigger & ~timerPrev
                     & ~softStart;
   wire startAny   = (softStart | timerStart) & ~forcedHalt;
   wire restart    = sequenceBusyFlag & passDone & repeatMode
                     & ~startAny & ~forcedHalt;
   wire full       = count == 5'(DEPTH);
   wire empty      = count == 5'h00;
   // apb has no read size: every read is a word read and advances
   wire pop        = rd & selFd & ~empty & ~fifoClear;
   wire push       = resultValid & ~full & ~fifoClear;
   wire overrun    = resultValid & full & ~fifoClear;
   wire [4:0] next_count = fifoClear ? 5'h00 :
                           5'(count + {4'h0, push} - {4'h0, pop});
   wire thrHit     = push & (next_count ==
      5'({1'b0, seqFifoThreshold} + 5'h01));

   // ----------------------------------------
   // interrupt requests
   // ----------------------------------------
   assign irqScan     = seqIrqEnable & seqIrqFlag;
   assign irqPriority = priorityIrqEnable & priorityIrqFlag;
   assign irqCompare  = compareIrqEnable & compareMatchFlag;
   assign irqOverrun  = overrunIrqEnable
                        & (seqOverrunFlag | priorityOverrunFlag);

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         seqIrqEnable        <= 1'b0;
         priorityIrqEnable   <= 1'b0;
         compareIrqEnable    <= 1'b0;
         overrunIrqEnable    <= 1'b0;
         placementSelect     <= 1'b0;
         repeatMode          <= 1'b0;
         seqTimerStartEnable <= 1'b0;
         seqFifoThreshold    <= `THR_RESET;
      end else begin
         if (wrIcHi) begin
            seqIrqEnable      <= pwdata[`B_SEQ_IRQ_EN];
            priorityIrqEnable <= pwdata[`B_PRI_IRQ_EN];
            compareIrqEnable  <= pwdata[`B_CMP_IRQ_EN];
            overrunIrqEnable  <= pwdata[`B_OVR_IRQ_EN];
         end
         if (wrStLo) begin
            placementSelect <= pwdata[`B_PLACEMENT];
         end
         if (wrScHi) begin
            // trusted: software touches repeat only when idle
            repeatMode          <= pwdata[`B_REPEAT];
            seqTimerStartEnable <= pwdata[`B_TIMER_EN];
         end
         if (wrThLo) begin
            seqFifoThreshold <= pwdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // sticky flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         seqIrqFlag       <= 1'b0;
         priorityIrqFlag  <= 1'b0;
         compareMatchFlag <= 1'b0;
         seqOverrunFlag   <= 1'b0;
      end else begin
         seqIrqFlag <= thrHit
            | (seqIrqFlag & ~(wrIcHi & ~pwdata[`B_SEQ_IRQ_FLAG]));
         priorityIrqFlag <= priorityIrqEvent
            | (priorityIrqFlag & ~(wrIcHi & ~pwdata[`B_PRI_IRQ_FLAG]));
         compareMatchFlag <= compareMatchEvent
            | (compareMatchFlag & ~(wrIcHi & ~pwdata[`B_CMP_FLAG]));
         seqOverrunFlag <= overrun
            | (seqOverrunFlag & ~(wrScHi & ~pwdata[`B_OVERRUN]));
      end
   end

   // ----------------------------------------
   // scan sequencing
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sequenceBusyFlag <= 1'b0;
         scanStartPulse   <= 1'b0;
         convHalt         <= 1'b0;
         timerPrev        <= 1'b0;
         runOrigin        <= `ORIGIN_SOFT;
      end else begin
         timerPrev      <= timerTrigger;
         scanStartPulse <= startAny | restart;
         convHalt       <= forcedHalt;
         if (forcedHalt) begin
            sequenceBusyFlag <= 1'b0;
         end else if (startAny) begin
            sequenceBusyFlag <= 1'b1;
         end else if (passDone & ~repeatMode) begin
            sequenceBusyFlag <= 1'b0;
         end
         if (startAny) begin
            runOrigin <= softStart ? `ORIGIN_SOFT : `ORIGIN_TIMER;
         end
      end
   end

   // ----------------------------------------
   // priority busy and pending
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         level1Active      <= 1'b0;
         level2Active      <= 1'b0;
         level2PendingFlag <= 1'b0;
      end else if (forcedHalt) begin
         level1Active      <= 1'b0;
         level2Active      <= 1'b0;
         level2PendingFlag <= 1'b0;
      end else begin
         if (level1Start) begin
            level1Active <= 1'b1;
         end else if (priorityDone & level1Active) begin
            level1Active <= 1'b0;
         end
         if (level2Start) begin
            level2Active <= 1'b1;
         end else if (priorityDone & ~level1Active) begin
            level2Active <= 1'b0;
         end
         // deferred level 2 resumes once level 1 finishes
         if ((level2Start & level1Active) | (level1Start & level2Active)) begin
            level2PendingFlag <= 1'b1;
         end else if (priorityDone & level1Active) begin
            level2PendingFlag <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // result fifo
   // ----------------------------------------
   entry_t newEntry;
   assign newEntry = '{value: resultValue, channel: resultChannel,
                       origin: runOrigin};

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clock) begin
         if (push && writePtr == 4'(i)) begin
            mem[i] <= newEntry;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         writePtr <= 4'h0;
         readPtr  <= 4'h0;
         count    <= 5'h00;
      end else begin
         count <= next_count;
         if (fifoClear) begin
            writePtr <= 4'h0;
            readPtr  <= 4'h0;
         end else begin
            if (push) begin
               writePtr <= 4'(writePtr + 4'h1);
            end
            if (pop) begin
               readPtr <= 4'(readPtr + 4'h1);
            end
         end
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   entry_t head;
   assign head = mem[readPtr];
   wire [31:0] dataWord =
      placementSelect ? {4'h0, head.value, 16'h0000}
                      : {head.value, 20'h00000};
   // reserved bits read zero
   wire [31:0] fifoWord = empty ? 32'h00001000 :
      dataWord | {22'h0, head.origin, 3'h0, head.channel};
   wire [31:0] icWord = {16'h0, seqIrqFlag, priorityIrqFlag,
      compareMatchFlag, 1'b0, seqIrqEnable, priorityIrqEnable,
      compareIrqEnable, overrunIrqEnable, 8'h00};
   // halt bit reads 0
   wire [31:0] stWord = {24'h0, 1'b0, placementSelect, 3'h0,
      level2PendingFlag, level1Active | level2Active,
      sequenceBusyFlag};
   // clear and start read 0
   wire [31:0] scWord = {16'h0, empty, full, seqOverrunFlag, 1'b0,
      1'b0, repeatMode, seqTimerStartEnable, 1'b0, 8'h00};
   wire [31:0] thWord = {28'h0, seqFifoThreshold};
   wire [31:0] readWord =
      selIc ? icWord :
      selSt ? stWord :
      selSc ? scWord :
      selTh ? thWord :
      selFd ? fifoWord : 32'h00000000;

   // sampled in setup so the access phase needs no wait state
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= readWord;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_overrun_drop;
      @(posedge clock) disable iff (!resetn)
      (resultValid & full & ~fifoClear & ~pop) |=> count == 5'(DEPTH)
         && seqOverrunFlag;
   endproperty
   a_overrun_drop: assert property (p_overrun_drop)
      else $error("result into full fifo not dropped");
   property p_clear_empties;
      @(posedge clock) disable iff (!resetn)
      fifoClear |=> empty && !full;
   endproperty
   a_clear_empties: assert property (p_clear_empties)
      else $error("fifo clear left data");
   property p_halt_idle;
      @(posedge clock) disable iff (!resetn)
      forcedHalt |=> !sequenceBusyFlag && !level2PendingFlag
         && !level1Active && !level2Active && convHalt;
   endproperty
   a_halt_idle: assert property (p_halt_idle)
      else $error("forced halt left a busy flag");
   property p_soft_wins;
      @(posedge clock) disable iff (!resetn)
      softStart & ~forcedHalt |=> scanStartPulse && sequenceBusyFlag
         && runOrigin == `ORIGIN_SOFT;
   endproperty
   a_soft_wins: assert property (p_soft_wins)
      else $error("soft start not honoured");
   property p_timer_start;
      @(posedge clock) disable iff (!resetn)
      seqTimerStartEnable && $rose(timerTrigger) && !wr
         |-> ##1 scanStartPulse ##0 runOrigin == `ORIGIN_TIMER;
   endproperty
   a_timer_start: assert property (p_timer_start)
      else $error("timer edge did not start scan");
   property p_single_stop;
      @(posedge clock) disable iff (!resetn)
      sequenceBusyFlag && passDone && !repeatMode && !startAny
         |=> !sequenceBusyFlag;
   endproperty
   a_single_stop: assert property (p_single_stop)
      else $error("single mode did not stop");
   property p_repeat_go;
      @(posedge clock) disable iff (!resetn)
      sequenceBusyFlag && passDone && repeatMode && !wr
         |=> sequenceBusyFlag && scanStartPulse;
   endproperty
   a_repeat_go: assert property (p_repeat_go)
      else $error("repeat mode did not restart");
   property p_threshold;
      @(posedge clock) disable iff (!resetn)
      push && !pop && count == 5'({1'b0, seqFifoThreshold}) |=> seqIrqFlag;
   endproperty
   a_threshold: assert property (p_threshold)
      else $error("scan flag missed threshold");
   property p_scan_irq;
      @(posedge clock) disable iff (!resetn)
      seqIrqFlag && seqIrqEnable |-> irqScan;
   endproperty
   a_scan_irq: assert property (p_scan_irq)
      else $error("scan request missing");
   property p_empty_reset;
      @(posedge clock) disable iff (!resetn)
      $rose(resetn) |-> empty && !full && !sequenceBusyFlag;
   endproperty
   a_empty_reset: assert property (p_empty_reset)
      else $error("fifo not empty after reset");

endmodule
`default_nettype wire

// File: shared/adc_scan_map.svh
// register map, field positions and reset values of the scan control block
// How it works
// - priority request out when its enable and priority flag are both set
// - compare request out when compare enable and compare match flag set
// - overrun request out when enabled and scan or priority overrun set
// - forced halt stops conversions, clears pending and busy flags, reads 0
// - placement select moves result to bits 27:16, lower half unchanged
// - pending set when levels 1 and 2 collide; level 2 is deferred
// - priority busy reads 1 while level 1 or 2 conversion runs
// - scan busy reads 1 while scan conversion is in progress
// - empty flag set when FIFO empties, cleared on store, resets to 1
// - full flag set when FIFO full, cleared by clear or data read
// - result into full FIFO sets overrun and is dropped; write 0 clears
// - writing 1 to FIFO clear empties FIFO; bit reads 0
// - repeat mode restarts after a pass; otherwise stop after the pass
// - enabled timer rising edge starts scan; software start still works
// - soft start begins scan, restarts if running, reads 0
// - soft start and timer edge together: soft start wins
// - scan flag set when stored count reaches threshold plus one
// - FIFO holds 16 results, read out in write order
// - default placement puts 12-bit result in bits 31:20
// - bit 12 of data word reads 1 when word holds no result
// - bits 9:8 tell the start origin; 01 is software
// - scan request out when scan enable and scan flag are both set
// - scan flag: write 0 clears, write 1 ignored
// - bits 4:0 of data word carry the channel number
// - FIFO advances on a read covering the top byte or a word read
`ifndef ADC_SCAN_MAP_SVH
`define ADC_SCAN_MAP_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define OFF_IRQ_CTRL   8'h00
`define OFF_STATUS     8'h04
`define OFF_SEQ_CTRL   8'h08
`define OFF_SEQ_THR    8'h0c
`define OFF_SEQ_DATA   8'h10
// ----------------------------------------
// fields
// ----------------------------------------
`define B_SEQ_IRQ_FLAG 15
`define B_PRI_IRQ_FLAG 14
`define B_CMP_FLAG     13
`define B_SEQ_IRQ_EN   11
`define B_PRI_IRQ_EN   10
`define B_CMP_IRQ_EN   9
`define B_OVR_IRQ_EN   8
`define B_HALT         7
`define B_PLACEMENT    6
`define B_PENDING      2
`define B_PRI_BUSY     1
`define B_SEQ_BUSY     0
`define B_EMPTY        15
`define B_FULL         14
`define B_OVERRUN      13
`define B_CLEAR        12
`define B_REPEAT       10
`define B_TIMER_EN     9
`define B_SOFT_START   8
`define B_INVALID      12
`define ORIGIN_SOFT    2'h1
`define ORIGIN_TIMER   2'h2
`define FIFO_DEPTH     16
`define THR_RESET      4'h0
`endif

// File: shared/adc_scan_pkg.sv
// types shared by the scan control block
package adc_scan_pkg;
   typedef logic [1:0] origin_t;
   typedef struct packed {
      logic [11:0] value;
      logic [4:0]  channel;
      origin_t     origin;
   } entry_t;
endpackage

// File: verification/adc_conv_model.sv
// behavioural converter core that answers scan starts with result pulses
`timescale 1ns/1ns
`default_nettype none
module adc_conv_model (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        startPulse,
   input  wire logic        halt,
   input  wire logic [3:0]  gap,
   input  wire logic [4:0]  passLength,
   output logic             resultValid,
   output logic [11:0]      resultValue,
   output logic [4:0]       resultChannel,
   output logic             passDone
);
   // ----------------------------------------
   // pass sequencer
   // ----------------------------------------
   logic [4:0] left;
   logic [4:0] idx;
   logic [3:0] waitCount;
   logic       lastOut;
   // gap sets the stall between results, from prompt to slow
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         left          <= 5'h0;
         idx           <= 5'h0;
         waitCount     <= 4'h0;
         lastOut       <= 1'b0;
         resultValid   <= 1'b0;
         passDone      <= 1'b0;
         resultValue   <= 12'h0;
         resultChannel <= 5'h0;
      end else begin
         resultValid   <= 1'b0;
         passDone      <= lastOut;
         lastOut       <= 1'b0;
         // stale result lines toggle so that no old value looks valid
         resultValue   <= ~resultValue;
         resultChannel <= ~resultChannel;
         if (halt) begin
            left <= 5'h0;
         end else if (startPulse) begin
            left      <= passLength;
            idx       <= 5'h0;
            waitCount <= gap;
         end else if (waitCount != 4'h0) begin
            waitCount <= waitCount - 4'h1;
         end else if (left != 5'h0) begin
            resultValid   <= 1'b1;
            resultValue   <= 12'ha50 ^ {7'h00, idx};
            resultChannel <= idx;
            idx           <= idx + 5'h1;
            left          <= left - 5'h1;
            waitCount     <= gap;
            lastOut       <= (left == 5'h1);
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/test_adc_scan_control.sv
// self-checking bench of the scan control block
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_map.svh"
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module test_adc_scan_control;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clock, resetn, psel, penable, pwrite, timerTrigger;
   logic        pready, pslverr, irqScan, irqPriority, irqCompare, irqOverrun;
   logic        scanStartPulse, convHalt, placementSelect, passDone;
   logic        resultValid, priorityOverrunFlag, errSeen, armTimer;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  pstrb, gap;
   logic [4:0]  evt, passLength, resultChannel;
   logic [11:0] resultValue;
   int          mismatches, checked, starts, halts;

   adc_scan_control i_dut (.clock, .resetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .timerTrigger,
      .resultValid, .resultValue, .resultChannel, .passDone,
      .priorityIrqEvent(evt[0]), .compareMatchEvent(evt[1]),
      .priorityOverrunFlag, .level1Start(evt[2]), .level2Start(evt[3]),
      .priorityDone(evt[4]), .irqScan, .irqPriority, .irqCompare,
      .irqOverrun, .scanStartPulse, .convHalt, .placementSelect);

   adc_conv_model i_conv (.clock, .resetn, .startPulse(scanStartPulse),
      .halt(convHalt), .gap, .passLength, .resultValid, .resultValue,
      .resultChannel, .passDone);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // counted mid-cycle so a task returning on the next edge sees the count
   always @(negedge clock) begin
      if (scanStartPulse === 1'b1) starts++;
      if (convHalt === 1'b1) halts++;
   end
   // ----------------------------------------
   // bus and helper tasks
   // ----------------------------------------
   // armTimer raises the timer line in the access cycle of a write
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      if (armTimer) timerTrigger <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdata   = prdata;
      errSeen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      `CHK(rdata, e, "register read")
   endtask
   // bounded poll; running out of polls counts as a mismatch
   task automatic waitIdle;
      int n;
      n = 0;
      do begin
         apb(`OFF_STATUS, 1'b0, 32'h0);
         n++;
      end while (rdata[`B_SEQ_BUSY] !== 1'b0 && n < 60);
      `CHK(rdata[`B_SEQ_BUSY], 1'b0, "scan stuck busy")
   endtask
   function automatic logic [31:0] word(input logic [4:0] k,
                                        input logic [1:0] org, input logic pl);
      logic [11:0] v;
      v = 12'ha50 ^ {7'h00, k};
      word = {(pl ? {4'h0, v} : {v, 4'h0}), 6'h00, org, 3'h0, k};
   endfunction
   task automatic drain(input int n, input int from, input logic [1:0] org,
                        input logic pl);
      for (int i = 0; i < n; i++) begin
         rd(`OFF_SEQ_DATA, word(5'(from + i), org, pl));
      end
   endtask
   task automatic pass(input logic [4:0] len, input logic [3:0] g,
                       input logic [31:0] ctl);
      passLength <= len;
      gap        <= g;
      wr(`OFF_SEQ_CTRL, ctl);
   endtask
   task automatic pulse(input int k);
      evt <= 5'h1 << k;
      @(posedge clock);
      evt <= 5'h0;
      @(posedge clock);
   endtask
   task automatic fin(input string s);
      $display("test %s finished", s);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      end_sim;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      int s;
      resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; pstrb = 4'hf; timerTrigger = 1'b0;
      evt = 5'h0; priorityOverrunFlag = 1'b0; armTimer = 1'b0;
      gap = 4'h0; passLength = 5'h0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(`OFF_IRQ_CTRL, 32'h0);
      rd(`OFF_STATUS, 32'h0);
      rd(`OFF_SEQ_CTRL, 32'h8000);
      rd(`OFF_SEQ_THR, 32'h0);
      rd(`OFF_SEQ_DATA, 32'h1000);
      apb(8'h14, 1'b0, 32'h0);
      `CHK(errSeen, 1'b1, "unmapped error")
      `CHK(rdata, 32'h0, "unmapped data")
      wr(`OFF_SEQ_THR, 32'hfff3);
      rd(`OFF_SEQ_THR, 32'h3);
      fin("reset");
      pass(5'd3, 4'd2, 32'h100);
      rd(`OFF_STATUS, 32'h1);
      waitIdle;
      `CHK(starts, 1, "single pass count")
      rd(`OFF_IRQ_CTRL, 32'h0);
      rd(`OFF_SEQ_CTRL, 32'h0);
      drain(3, 0, 2'b01, 1'b0);
      rd(`OFF_SEQ_CTRL, 32'h8000);
      fin("single pass");
      wr(`OFF_SEQ_THR, 32'h2);
      pass(5'd3, 4'd0, 32'h100);
      waitIdle;
      rd(`OFF_IRQ_CTRL, 32'h8000);
      `CHK(irqScan, 1'b0, "scan request off")
      wr(`OFF_IRQ_CTRL, 32'h8800);
      `CHK(irqScan, 1'b1, "scan request on")
      wr(`OFF_IRQ_CTRL, 32'h0800);
      `CHK(irqScan, 1'b0, "scan flag cleared")
      wr(`OFF_SEQ_CTRL, 32'h1000);
      rd(`OFF_SEQ_CTRL, 32'h8000);
      rd(`OFF_SEQ_DATA, 32'h1000);
      fin("threshold");
      wr(`OFF_SEQ_THR, 32'hf);
      wr(`OFF_IRQ_CTRL, 32'h0100);
      pass(5'd17, 4'd0, 32'h100);
      waitIdle;
      rd(`OFF_SEQ_CTRL, 32'h6000);
      rd(`OFF_IRQ_CTRL, 32'h8100);
      `CHK(irqOverrun, 1'b1, "overrun request")
      drain(1, 0, 2'b01, 1'b0);
      rd(`OFF_SEQ_CTRL, 32'h2000);
      drain(15, 1, 2'b01, 1'b0);
      rd(`OFF_SEQ_DATA, 32'h1000);
      wr(`OFF_SEQ_CTRL, 32'h2000);
      rd(`OFF_SEQ_CTRL, 32'ha000);
      wr(`OFF_SEQ_CTRL, 32'h0);
      rd(`OFF_SEQ_CTRL, 32'h8000);
      `CHK(irqOverrun, 1'b0, "overrun cleared")
      wr(`OFF_IRQ_CTRL, 32'h0);
      fin("overrun");
      wr(`OFF_STATUS, 32'h40);
      rd(`OFF_STATUS, 32'h40);
      `CHK(placementSelect, 1'b1, "placement")
      pass(5'd1, 4'd3, 32'h100);
      waitIdle;
      drain(1, 0, 2'b01, 1'b1);
      wr(`OFF_STATUS, 32'h0);
      fin("placement");
      s = starts;
      timerTrigger <= 1'b1;
      repeat (3) @(posedge clock);
      timerTrigger <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK(starts, s, "timer disabled")
      pass(5'd1, 4'd0, 32'h200);
      timerTrigger <= 1'b1;
      repeat (3) @(posedge clock);
      timerTrigger <= 1'b0;
      waitIdle;
      drain(1, 0, 2'b10, 1'b0);
      armTimer = 1'b1;
      wr(`OFF_SEQ_CTRL, 32'h300);
      armTimer = 1'b0;
      timerTrigger <= 1'b0;
      waitIdle;
      `CHK(starts, s + 2, "soft and timer")
      drain(1, 0, 2'b01, 1'b0);
      wr(`OFF_SEQ_CTRL, 32'h0);
      fin("timer");
      s = starts;
      pass(5'd8, 4'd5, 32'h100);
      repeat (8) @(posedge clock);
      wr(`OFF_SEQ_CTRL, 32'h100);
      `CHK(starts, s + 2, "restart")
      rd(`OFF_STATUS, 32'h1);
      waitIdle;
      wr(`OFF_SEQ_CTRL, 32'h1000);
      s = starts;
      pass(5'd2, 4'd1, 32'h500);
      repeat (40) @(posedge clock);
      `CHK(starts > s + 2, 1'b1, "repeat")
      pulse(3);
      rd(`OFF_STATUS, 32'h3);
      pulse(2);
      rd(`OFF_STATUS, 32'h7);
      pulse(4);
      rd(`OFF_STATUS, 32'h3);
      s = halts;
      wr(`OFF_STATUS, 32'h80);
      rd(`OFF_STATUS, 32'h0);
      `CHK(halts, s + 1, "halt pulse")
      s = starts;
      repeat (20) @(posedge clock);
      `CHK(starts, s, "halt stops repeat")
      wr(`OFF_SEQ_CTRL, 32'h1000);
      fin("control");
      // repeat passes may have reached the threshold: drop the scan flag
      wr(`OFF_IRQ_CTRL, 32'h0);
      pulse(0);
      `CHK(irqPriority, 1'b0, "priority off")
      rd(`OFF_IRQ_CTRL, 32'h4000);
      wr(`OFF_IRQ_CTRL, 32'h4400);
      `CHK(irqPriority, 1'b1, "priority on")
      pulse(1);
      wr(`OFF_IRQ_CTRL, 32'h6200);
      `CHK(irqCompare, 1'b1, "compare on")
      `CHK(irqPriority, 1'b0, "priority masked")
      priorityOverrunFlag <= 1'b1;
      wr(`OFF_IRQ_CTRL, 32'h6100);
      `CHK(irqOverrun, 1'b1, "priority overrun")
      `CHK(irqCompare, 1'b0, "compare masked")
      wr(`OFF_IRQ_CTRL, 32'h0100);
      rd(`OFF_IRQ_CTRL, 32'h0100);
      fin("requests");
      end_sim;
   end
endmodule
`default_nettype wire
